/* core/clkgen_regs.svh */
// register indices, field positions, reset values of the clock generator control
// assumes an APB slave maps index n to byte address 4*n
//
// Overview of operation
// [RQ1] after reset the cpu always runs from the internal fast oscillator
// [RQ2] stop mode or main halt bit 7 stops the main crystal oscillator
// [RQ3] stop mode or main halt bit disables the external main clock input
// [RQ4] stop mode or fast halt bit 0 stops the internal fast oscillator
// [RQ5] stop mode or clearing enable bit 0 stops the double-speed oscillator
// [RQ6] source select bit 4 picks high-speed clock or internal fast clock
// [RQ7] double-speed select bit 2 routes the double-speed clock as main clock
// [RQ8] sub halt bit 6 stops the subsystem crystal oscillator
// [RQ9] the low-speed clock feeds only the watchdog, never the cpu
// [RQ10] the low-speed oscillator runs exactly while the watchdog runs
// [RQ11] watchdog stops when disabled, or in standby without standby-run option
// [RQ12] pin mode register takes one 8-bit write per reset; reads always allowed
// [RQ13] reset clears the pin mode register to zero
// [RQ14] pin mode fields at bits 7,6,4,2-1,0; bits 5 and 3 read zero
// [RQ15] pin pair 00/10 port, 01 crystal, 11 external clock input
// [RQ16] reset loads run control with both crystal halts set, fast oscillator on
// [RQ17] frequency range bit: 0 up to 10 MHz, 1 above 10 MHz
// [RQ18] later writes to the pin mode register are silently ignored until reset
// [RQ19] source changes only while old and new clocks are both low
`ifndef CLKGEN_REGS_SVH
`define CLKGEN_REGS_SVH
// -----------------------------------------------
// register indices
// -----------------------------------------------
`define PIN_MODE_IDX 20'hfffa0
`define RUN_CTRL_IDX 20'hfffa1
`define CLK_SEL_IDX 20'hfffa4
`define DBL_CTRL_IDX 20'hfffa5
`define OPTION_IDX 20'h000c0
// -----------------------------------------------
// reset values and implemented-bit masks
// -----------------------------------------------
`define PIN_MODE_RST 8'h00
`define RUN_CTRL_RST 8'hc0
`define CLK_SEL_RST 8'h00
`define DBL_CTRL_RST 8'h00
`define OPTION_RST 8'h00
`define PIN_MODE_MASK 8'hd7
`define RUN_CTRL_MASK 8'hc1
`define CLK_SEL_MASK 8'h10
`define DBL_CTRL_MASK 8'h05
`define OPTION_MASK 8'h11
// -----------------------------------------------
// field positions
// -----------------------------------------------
`define EXT_CLK_BIT 7
`define MAIN_PIN_BIT 6
`define SUB_PIN_BIT 4
`define SUB_GAIN_HI_BIT 2
`define SUB_GAIN_LO_BIT 1
`define FREQ_RANGE_BIT 0
`define MAIN_HALT_BIT 7
`define SUB_HALT_BIT 6
`define FAST_HALT_BIT 0
`define SRC_SEL_BIT 4
`define DBL_SEL_BIT 2
`define DBL_EN_BIT 0
`define WD_EN_BIT 4
`define WD_STBY_BIT 0
`endif

/* core/clkgen_pkg.sv */
// types shared by the clock generator control
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package clkgen_pkg;
  typedef enum logic [1:0] {SRC_FAST, SRC_HS, SRC_DBL} src_t;
  typedef enum logic [1:0] {PIN_PORT, PIN_XTAL, PIN_EXT} pin_mode_t;
endpackage
`default_nettype wire

/* core/system_clock_generator_control.sv */
// clock generator control: oscillator run/stop, main clock source, watchdog clock
// assumes oscillator clock levels arrive sampled and synchronous to pclk
`include "clkgen_regs.svh"
`default_nettype none
module system_clock_generator_control
  import clkgen_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic stop_mode,
  input wire logic halt_mode,
  input wire logic fast_clk_lvl,
  input wire logic hs_clk_lvl,
  input wire logic dbl_clk_lvl,
  output logic main_osc_run,
  output logic ext_clk_in_en,
  output logic fast_osc_run,
  output logic dbl_osc_run,
  output logic sub_osc_run,
  output logic low_osc_run,
  output logic watchdog_running,
  output pin_mode_t main_pin_mode,
  output logic sub_pin_osc,
  output logic [1:0] sub_gain,
  output logic main_freq_range,
  output src_t main_src,
  output logic main_clk
);
  // -----------------------------------------------
  // decode helpers
  // -----------------------------------------------
  function automatic logic idx_hit(input logic [31:0] a, input logic [19:0] idx);
    idx_hit = (a[31:22] == 10'h000) && (a[21:2] == idx) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic src_lvl(input src_t s, input logic f, input logic h,
                                   input logic d);
    unique case (s)
      SRC_FAST: src_lvl = f;
      SRC_HS: src_lvl = h;
      SRC_DBL: src_lvl = d;
      default: src_lvl = f;
    endcase
  endfunction

  // -----------------------------------------------
  // registers
  // -----------------------------------------------
  logic [7:0] pin_mode_ff;
  logic [7:0] run_ctrl_ff;
  logic [7:0] clk_sel_ff;
  logic [7:0] dbl_ctrl_ff;
  logic [7:0] option_ff;
  logic pin_locked_ff;
  logic ready_ff;
  logic err_ff;
  logic [31:0] rdata_ff;
  src_t src_ff;
  logic clk_ff;
  logic main_osc_ff;
  logic ext_en_ff;
  logic fast_ff;
  logic dbl_ff;
  logic sub_ff;
  logic wd_ff;
  pin_mode_t pin_dec_ff;

  // -----------------------------------------------
  // apb decode
  // -----------------------------------------------
  wire hit_pin = idx_hit(paddr, `PIN_MODE_IDX);
  wire hit_run = idx_hit(paddr, `RUN_CTRL_IDX);
  wire hit_sel = idx_hit(paddr, `CLK_SEL_IDX);
  wire hit_dbl = idx_hit(paddr, `DBL_CTRL_IDX);
  wire hit_opt = idx_hit(paddr, `OPTION_IDX);
  wire mapped = hit_pin | hit_run | hit_sel | hit_dbl | hit_opt;
  wire setup = psel & ~penable;
  wire xfer = psel & penable & ready_ff;
  wire wr_lo = xfer & pwrite & pstrb[0] & mapped;
  // only a byte-wide store counts as the one allowed write
  wire byte_store = (pstrb == 4'h1);
  wire wr_pin = wr_lo & hit_pin & byte_store & ~pin_locked_ff; // RQ12 RQ18
  wire [7:0] wbyte = pwdata[7:0];
  wire [7:0] rd_sel = hit_pin ? pin_mode_ff :
                      hit_run ? run_ctrl_ff :
                      hit_sel ? clk_sel_ff :
                      hit_dbl ? dbl_ctrl_ff :
                      hit_opt ? option_ff : 8'h00;

  // -----------------------------------------------
  // clock control decode
  // -----------------------------------------------
  wire [1:0] pin_pair = {pin_mode_ff[`EXT_CLK_BIT], pin_mode_ff[`MAIN_PIN_BIT]};
  wire is_xtal = (pin_pair == 2'b01); // RQ15
  wire is_ext = (pin_pair == 2'b11); // RQ15
  wire pin_port = ~pin_mode_ff[`MAIN_PIN_BIT]; // RQ15
  // decoded pin mode is registered so the output leaves a flip-flop like the rest
  wire pin_mode_t nxt_pin_dec = pin_port ? PIN_PORT : (is_xtal ? PIN_XTAL : PIN_EXT); // RQ15
  wire nxt_main_osc = is_xtal & ~run_ctrl_ff[`MAIN_HALT_BIT] & ~stop_mode; // RQ2
  wire nxt_ext_en = is_ext & ~run_ctrl_ff[`MAIN_HALT_BIT] & ~stop_mode; // RQ3
  wire nxt_fast = ~run_ctrl_ff[`FAST_HALT_BIT] & ~stop_mode; // RQ4
  wire nxt_dbl = dbl_ctrl_ff[`DBL_EN_BIT] & ~stop_mode; // RQ5
  wire nxt_sub = pin_mode_ff[`SUB_PIN_BIT] & ~run_ctrl_ff[`SUB_HALT_BIT]; // RQ8
  wire standby = halt_mode | stop_mode;
  wire nxt_wd = option_ff[`WD_EN_BIT] & ~(standby & ~option_ff[`WD_STBY_BIT]); // RQ11
  // low-speed clock has no entry in the source list at all
  wire src_t want_src = dbl_ctrl_ff[`DBL_SEL_BIT] ? SRC_DBL : // RQ7 RQ9
                        clk_sel_ff[`SRC_SEL_BIT] ? SRC_HS : SRC_FAST; // RQ6
  wire old_lvl = src_lvl(src_ff, fast_clk_lvl, hs_clk_lvl, dbl_clk_lvl);
  wire new_lvl = src_lvl(want_src, fast_clk_lvl, hs_clk_lvl, dbl_clk_lvl);
  // handing over while both are low keeps every high phase whole
  wire swap_ok = (want_src != src_ff) & ~old_lvl & ~new_lvl;
  wire src_t nxt_src = swap_ok ? want_src : src_ff; // RQ19

  // -----------------------------------------------
  // register file
  // -----------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_mode_ff <= `PIN_MODE_RST; // RQ13
      pin_locked_ff <= 1'b0;
    end else if (wr_pin) begin
      pin_mode_ff <= wbyte & `PIN_MODE_MASK; // RQ14
      pin_locked_ff <= 1'b1; // RQ18
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_ctrl_ff <= `RUN_CTRL_RST; // RQ16
      clk_sel_ff <= `CLK_SEL_RST;
      dbl_ctrl_ff <= `DBL_CTRL_RST;
      option_ff <= `OPTION_RST;
    end else begin
      if (wr_lo & hit_run) run_ctrl_ff <= wbyte & `RUN_CTRL_MASK;
      if (wr_lo & hit_sel) clk_sel_ff <= wbyte & `CLK_SEL_MASK;
      if (wr_lo & hit_dbl) dbl_ctrl_ff <= wbyte & `DBL_CTRL_MASK;
      if (wr_lo & hit_opt) option_ff <= wbyte & `OPTION_MASK;
    end
  end

  // zero wait states: ready rises in the access phase after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_ff <= 1'b0;
      err_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end else begin
      ready_ff <= setup;
      err_ff <= setup & ~mapped;
      if (setup) rdata_ff <= {24'h00_0000, rd_sel};
    end
  end

  // -----------------------------------------------
  // oscillator control and clock selection
  // -----------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_osc_ff <= 1'b0;
      ext_en_ff <= 1'b0;
      fast_ff <= 1'b1;
      dbl_ff <= 1'b0;
      sub_ff <= 1'b0;
      wd_ff <= 1'b0;
      pin_dec_ff <= PIN_PORT;
    end else begin
      main_osc_ff <= nxt_main_osc;
      ext_en_ff <= nxt_ext_en;
      fast_ff <= nxt_fast;
      dbl_ff <= nxt_dbl;
      sub_ff <= nxt_sub;
      wd_ff <= nxt_wd; // RQ10
      pin_dec_ff <= nxt_pin_dec;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_ff <= SRC_FAST; // RQ1
      clk_ff <= 1'b0;
    end else begin
      src_ff <= nxt_src;
      clk_ff <= src_lvl(nxt_src, fast_clk_lvl, hs_clk_lvl, dbl_clk_lvl);
    end
  end

  // -----------------------------------------------
  // outputs
  // -----------------------------------------------
  assign prdata = rdata_ff;
  assign pready = ready_ff;
  assign pslverr = err_ff;
  assign main_osc_run = main_osc_ff;
  assign ext_clk_in_en = ext_en_ff;
  assign fast_osc_run = fast_ff;
  assign dbl_osc_run = dbl_ff;
  assign sub_osc_run = sub_ff;
  assign low_osc_run = wd_ff; // RQ9 RQ10
  assign watchdog_running = wd_ff;
  assign main_pin_mode = pin_dec_ff;
  assign sub_pin_osc = pin_mode_ff[`SUB_PIN_BIT];
  assign sub_gain = {pin_mode_ff[`SUB_GAIN_HI_BIT], pin_mode_ff[`SUB_GAIN_LO_BIT]};
  assign main_freq_range = pin_mode_ff[`FREQ_RANGE_BIT]; // RQ17
  assign main_src = src_ff;
  assign main_clk = clk_ff;

  // -----------------------------------------------
  // assertions
  // -----------------------------------------------
  sequence s_pin_write;
    xfer & pwrite & hit_pin & byte_store;
  endsequence

  sequence s_locked_write;
    s_pin_write ##0 pin_locked_ff;
  endsequence

  property p_pin_hold;
    @(posedge pclk) disable iff (!presetn)
      s_locked_write |=> $stable(pin_mode_ff);
  endproperty

  AST_PIN_ONCE: assert property (p_pin_hold) // RQ18
    else $error("pin mode changed after its one write");

  AST_PIN_FIRST: assert property (@(posedge pclk) disable iff (!presetn) // RQ12
      s_pin_write ##0 !pin_locked_ff |=> pin_locked_ff &&
        pin_mode_ff == ($past(pwdata[7:0]) & 8'hd7))
    else $error("first byte write to pin mode not taken");

  AST_PIN_RSVD: assert property (@(posedge pclk) disable iff (!presetn) // RQ14
      pin_mode_ff[5] == 1'b0 && pin_mode_ff[3] == 1'b0)
    else $error("reserved pin mode bits not zero");

  AST_PIN_DEC: assert property (@(posedge pclk) disable iff (!presetn) // RQ15
      main_pin_mode == PIN_XTAL |-> $past(!pin_mode_ff[7] && pin_mode_ff[6]))
    else $error("crystal mode shown without its pin pair");

  AST_MAIN_STOP: assert property (@(posedge pclk) disable iff (!presetn) // RQ2
      stop_mode || run_ctrl_ff[7] |=> !main_osc_run && !ext_clk_in_en)
    else $error("main oscillator or external input alive while stopped");

  AST_EXT_MODE: assert property (@(posedge pclk) disable iff (!presetn) // RQ3
      ext_clk_in_en |-> main_pin_mode == PIN_EXT && !main_osc_run)
    else $error("external input enabled outside external clock mode");

  AST_FAST_STOP: assert property (@(posedge pclk) disable iff (!presetn) // RQ4
      $rose(stop_mode) |=> !fast_osc_run && !dbl_osc_run)
    else $error("fast oscillators still run in stop mode");

  AST_FAST_RUN: assert property (@(posedge pclk) disable iff (!presetn) // RQ4
      !run_ctrl_ff[0] && !stop_mode |=> fast_osc_run)
    else $error("fast oscillator stopped without a halt");

  AST_DBL_RUN: assert property (@(posedge pclk) disable iff (!presetn) // RQ5
      dbl_ctrl_ff[0] && !stop_mode |=> dbl_osc_run)
    else $error("double-speed oscillator not running when enabled");

  AST_SUB_STOP: assert property (@(posedge pclk) disable iff (!presetn) // RQ8
      run_ctrl_ff[6] |=> !sub_osc_run)
    else $error("subsystem oscillator runs while halted");

  AST_SUB_RUN: assert property (@(posedge pclk) disable iff (!presetn) // RQ8
      pin_mode_ff[4] && !run_ctrl_ff[6] |=> sub_osc_run)
    else $error("subsystem oscillator stopped without a halt");

  AST_WD_STBY: assert property (@(posedge pclk) disable iff (!presetn) // RQ11
      option_ff[4] && !option_ff[0] && halt_mode |=> !watchdog_running
        && !low_osc_run)
    else $error("watchdog clock runs in standby without option");

  AST_WD_OFF: assert property (@(posedge pclk) disable iff (!presetn) // RQ11
      !option_ff[4] |=> !watchdog_running && !low_osc_run)
    else $error("watchdog clock runs while the watchdog is disabled");

  AST_WD_TIE: assert property (@(posedge pclk) disable iff (!presetn) // RQ10
      low_osc_run == watchdog_running)
    else $error("low-speed oscillator out of step with watchdog");

  AST_READY_ONE: assert property (@(posedge pclk) disable iff (!presetn)
      pready |=> !pready)
    else $error("ready held longer than one access cycle");

  // a source change is seen one edge after the hand-over edge itself
  sequence s_src_change;
    main_src != $past(main_src);
  endsequence

  AST_SRC_SAFE: assert property (@(posedge pclk) disable iff (!presetn) // RQ19
      s_src_change |-> !main_clk && !$past(old_lvl))
    else $error("source switched while the old or new clock was high");

  AST_DBL_ROUTE: assert property (@(posedge pclk) disable iff (!presetn) // RQ7
      s_src_change ##0 main_src == SRC_DBL |-> $past(dbl_ctrl_ff[2]))
    else $error("double-speed clock routed without its select");

  AST_RESET_SRC: assert property (@(posedge pclk) // RQ1 RQ16
      $rose(presetn) |-> main_src == SRC_FAST && run_ctrl_ff == 8'hc0)
    else $error("wrong source or run control after reset");

  AST_HS_SEL: assert property (@(posedge pclk) disable iff (!presetn) // RQ6
      s_src_change ##0 main_src == SRC_HS |->
        $past(clk_sel_ff[4] && !dbl_ctrl_ff[2]))
    else $error("high-speed source taken without select bit");

endmodule
`default_nettype wire

/* test/test_system_clock_generator_control.sv */
// self-checking bench for the clock generator control: apb tasks and directed tests
// assumes the design answers apb in one registered access cycle, outputs one edge later
`include "clkgen_regs.svh"
`default_nettype none
module test_system_clock_generator_control
  import clkgen_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
  logic [3:0] pstrb = 4'h0;
  logic pready, pslverr, stop_mode = 1'b0, halt_mode = 1'b0;
  logic fast_clk_lvl = 1'b0, hs_clk_lvl = 1'b0, dbl_clk_lvl = 1'b0;
  logic main_osc_run, ext_clk_in_en, fast_osc_run, dbl_osc_run, sub_osc_run;
  logic low_osc_run, watchdog_running, sub_pin_osc, main_freq_range, main_clk;
  logic [1:0] sub_gain;
  pin_mode_t main_pin_mode;
  src_t main_src;
  logic [2:0] lvl_cnt = 3'h0;
  logic [31:0] rdat;
  logic rerr, hlev;
  int n_fail = 0, n_checks = 0;
  system_clock_generator_control u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .stop_mode(stop_mode),
    .halt_mode(halt_mode), .fast_clk_lvl(fast_clk_lvl), .hs_clk_lvl(hs_clk_lvl),
    .dbl_clk_lvl(dbl_clk_lvl), .main_osc_run(main_osc_run), .ext_clk_in_en(ext_clk_in_en),
    .fast_osc_run(fast_osc_run), .dbl_osc_run(dbl_osc_run), .sub_osc_run(sub_osc_run),
    .low_osc_run(low_osc_run), .watchdog_running(watchdog_running),
    .main_pin_mode(main_pin_mode), .sub_pin_osc(sub_pin_osc), .sub_gain(sub_gain),
    .main_freq_range(main_freq_range), .main_src(main_src), .main_clk(main_clk));
  // ---------------------------------------------
  // clock and oscillator levels
  // ---------------------------------------------
  always #2 pclk = ~pclk;
  // three rates from one counter, each half the last, so every source change has to wait for common low phases
  always @(posedge pclk) begin
    lvl_cnt <= lvl_cnt + 3'h1;
    fast_clk_lvl <= lvl_cnt[0];
    hs_clk_lvl <= lvl_cnt[1];
    dbl_clk_lvl <= lvl_cnt[2];
  end
  // ---------------------------------------------
  // tasks
  // ---------------------------------------------
  task automatic summarize();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp) begin
      n_fail = n_fail + 1;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [31:0] a, input logic [7:0] d,
                     input logic [3:0] st);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    pstrb <= st;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k = k + 1;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) n_fail = n_fail + 1;
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [19:0] idx, input logic [7:0] d);
    apb(1'b1, {10'h0, idx, 2'b00}, d, 4'h1);
  endtask
  task automatic rd(input logic [19:0] idx);
    apb(1'b0, {10'h0, idx, 2'b00}, 8'h00, 4'h0);
  endtask
  task automatic settle();
    repeat (2) @(posedge pclk);
    #1;
  endtask
  task automatic do_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    settle();
  endtask
  task automatic drive_mode(input logic s, input logic h);
    @(posedge pclk);
    stop_mode <= s;
    halt_mode <= h;
    settle();
  endtask
  task automatic wait_src(input logic [1:0] s);
    int k;
    for (k = 0; k < 40 && main_src !== s; k++) @(posedge pclk);
    #1;
    chk(32'(main_src), 32'(s));
    for (k = 0; k < 4; k++) begin
      @(posedge pclk);
      hlev = (s == SRC_HS) ? hs_clk_lvl : (s == SRC_DBL) ? dbl_clk_lvl : fast_clk_lvl;
      #1;
      chk(32'(main_clk), 32'(hlev));
    end
  endtask
  // ---------------------------------------------
  // tests
  // ---------------------------------------------
  initial begin
    #40000;
    n_fail = n_fail + 1;
    summarize();
  end
  initial begin
    logic [19:0] idx [5] = '{`PIN_MODE_IDX, `RUN_CTRL_IDX, `CLK_SEL_IDX, `DBL_CTRL_IDX,
                             `OPTION_IDX};
    logic [7:0] rst [5] = '{8'h00, 8'hc0, 8'h00, 8'h00, 8'h00};
    logic [7:0] pv [4] = '{8'h00, 8'h40, 8'h80, 8'hc0};
    logic [1:0] pm [4] = '{PIN_PORT, PIN_XTAL, PIN_PORT, PIN_EXT};
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    settle();
    chk(32'(fast_osc_run), 32'h1);
    chk(32'(main_src), 32'(SRC_FAST));
    chk(32'(main_osc_run), 32'h0);
    for (int i = 0; i < 5; i++) begin
      rd(idx[i]);
      chk(rdat, {24'h0, rst[i]});
    end
    // unmapped word answers with an error and zero data
    apb(1'b0, 32'h4, 8'h00, 4'h0);
    chk({31'h0, rerr}, 32'h1);
    chk(rdat, 32'h0);
    for (int i = 0; i < 4; i++) begin
      do_reset();
      wr(`PIN_MODE_IDX, pv[i]);
      settle();
      chk(32'(main_pin_mode), 32'(pm[i]));
    end
    // a wide write does not use up the single write
    do_reset();
    apb(1'b1, {10'h0, `PIN_MODE_IDX, 2'b00}, 8'hff, 4'hf);
    rd(`PIN_MODE_IDX);
    chk(rdat, 32'h0);
    wr(`PIN_MODE_IDX, 8'hff);
    rd(`PIN_MODE_IDX);
    chk(rdat, 32'hd7);
    chk({28'h0, sub_pin_osc, sub_gain, main_freq_range}, 32'hf);
    wr(`PIN_MODE_IDX, 8'h00);
    rd(`PIN_MODE_IDX);
    chk(rdat, 32'hd7);
    wr(`RUN_CTRL_IDX, 8'h00);
    settle();
    chk({29'h0, ext_clk_in_en, main_osc_run, sub_osc_run}, 32'h5);
    wr(`RUN_CTRL_IDX, 8'h40);
    settle();
    chk(32'(sub_osc_run), 32'h0);
    drive_mode(1'b1, 1'b0);
    chk({30'h0, ext_clk_in_en, fast_osc_run}, 32'h0);
    drive_mode(1'b0, 1'b0);
    chk({30'h0, ext_clk_in_en, fast_osc_run}, 32'h3);
    wr(`RUN_CTRL_IDX, 8'h81);
    settle();
    chk({30'h0, ext_clk_in_en, fast_osc_run}, 32'h0);
    // crystal mode on a fresh reset
    do_reset();
    wr(`PIN_MODE_IDX, 8'h41);
    wr(`RUN_CTRL_IDX, 8'h00);
    settle();
    chk({30'h0, main_osc_run, ext_clk_in_en}, 32'h2);
    drive_mode(1'b1, 1'b0);
    chk(32'(main_osc_run), 32'h0);
    drive_mode(1'b0, 1'b0);
    wr(`RUN_CTRL_IDX, 8'h80);
    settle();
    chk(32'(main_osc_run), 32'h0);
    wr(`DBL_CTRL_IDX, 8'h01);
    settle();
    chk(32'(dbl_osc_run), 32'h1);
    drive_mode(1'b1, 1'b0);
    chk(32'(dbl_osc_run), 32'h0);
    drive_mode(1'b0, 1'b0);
    wr(`DBL_CTRL_IDX, 8'h00);
    settle();
    chk(32'(dbl_osc_run), 32'h0);
    // watchdog and its low-speed oscillator move together
    wr(`OPTION_IDX, 8'h10);
    settle();
    chk({30'h0, watchdog_running, low_osc_run}, 32'h3);
    drive_mode(1'b0, 1'b1);
    chk({30'h0, watchdog_running, low_osc_run}, 32'h0);
    wr(`OPTION_IDX, 8'h11);
    settle();
    chk({30'h0, watchdog_running, low_osc_run}, 32'h3);
    drive_mode(1'b1, 1'b0);
    chk({30'h0, watchdog_running, low_osc_run}, 32'h3);
    drive_mode(1'b0, 1'b0);
    wr(`OPTION_IDX, 8'h00);
    settle();
    chk({30'h0, watchdog_running, low_osc_run}, 32'h0);
    // source changes
    wr(`CLK_SEL_IDX, 8'h10);
    wait_src(SRC_HS);
    wr(`DBL_CTRL_IDX, 8'h05);
    wait_src(SRC_DBL);
    wr(`DBL_CTRL_IDX, 8'h01);
    wait_src(SRC_HS);
    do_reset();
    chk(32'(main_src), 32'(SRC_FAST));
    wait_src(SRC_FAST);
    summarize();
  end
endmodule
`default_nettype wire
